// [core/erase_seq_pkg.sv]
// Constants, encodings and carrier types for the serial flash erase sequencer
package erase_seq_pkg;

   // Opcodes
   localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h7c;
   localparam logic [7:0] OP_CHIP_ERASE_0 = 8'hc7;
   localparam logic [7:0] OP_CHIP_ERASE_1 = 8'h94;
   localparam logic [7:0] OP_CHIP_ERASE_2 = 8'h80;
   localparam logic [7:0] OP_CHIP_ERASE_3 = 8'h9a;

   // Frame shape
   localparam int          CMD_BYTES  = 4;
   localparam logic [2:0]  BYTE_CNT_W = 3'h4;    // Opcode plus three address bytes
   localparam logic [2:0]  BIT_LAST   = 3'h7;
   localparam logic [2:0]  ADDR_LSB_B = 3'h0;

   // Page address layout inside the 24-bit address field
   localparam int          PAGE_W        = 12;
   localparam int          PAGE_LSB_264  = 9;    // 3 dummy, PA11..PA0, 9 byte bits
   localparam int          PAGE_LSB_256  = 8;    // 4 dummy, A19..A8, 8 byte bits
   localparam int          BLK_LSB       = 3;    // Block index is page bits 11..3
   localparam int          SEC_LSB       = 8;    // Sector number is page bits 11..8
   localparam int          SUB_BIT       = 3;    // Picks sub-sector 0a or 0b

   // Region extents in pages
   localparam logic [11:0] PAGE_ZERO     = 12'h000;
   localparam logic [11:0] PAGE_LAST     = 12'hfff;
   localparam logic [11:0] BLK_SPAN      = 12'h007;
   localparam logic [11:0] SUB_0B_FIRST  = 12'h008;
   localparam logic [11:0] SEC_SPAN      = 12'h0ff;
   localparam logic [3:0]  SEC_NONE      = 4'h0;

   // Protection mask layout: bits 1..15 sectors, bit 0 sub 0a, bit 16 sub 0b
   localparam int          PROT_W        = 17;
   localparam logic [4:0]  PROT_IDX_0B   = 5'h10;

   // Clock
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          NS_PER_US     = 1000;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SCAN  = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_DONE  = 4'b1000
   } seq_state_t;

   typedef enum logic [1:0] {
      KIND_NONE   = 2'h0,
      KIND_BLOCK  = 2'h1,
      KIND_SECTOR = 2'h2,
      KIND_CHIP   = 2'h3
   } erase_kind_t;

   // Serial pins as seen by the device
   typedef struct packed {
      logic sck;
      logic cs_n;
      logic mosi;
   } spi_pins_t;

   // Decoded erase request
   typedef struct packed {
      erase_kind_t kind;
      logic [11:0] first;
      logic [11:0] last;
   } erase_cmd_t;

endpackage

// [core/sync_2ff.sv]
// Two-stage synchroniser for levels arriving from another clock domain
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule

// [core/erase_seq.sv]
// Erase command decoder and self-timed erase sequencer behind the serial port
// Operation
// - Opcode 50h erases one aligned eight-page block
// - 264 mode block: 3 dummy, PA11-3, 12 dummy
// - 256 mode block: 4 dummy, A19-11, 11 dummy
// - Chip select rise starts block erase, busy held
// - Block index is page bits 11..3
// - Failed byte erase sets erase/program error flag
// - Opcode 7Ch erases exactly one sector
// - 264 mode sub-sector 0a/0b: PA11-3 layout
// - 256 mode sub-sector 0a/0b: A19-11 layout
// - 256 mode sectors 1-15: A19-16 layout
// - Sector from page bits 11..8; zero uses bit 3
// - Any page in sector; chip select rise starts
// - Chip erase needs C7h 94h 80h 9Ah exactly
// - Bytes after fourth chip erase byte ignored
// - Chip select rise starts chip erase, busy held
// - Chip erase skips protected or locked sectors
// - Write protect change waits for erase end
// - Erased bytes must read back all ones
`timescale 1ns/1ps
module erase_seq
   import erase_seq_pkg::*;
#(
   parameter int BLOCK_ERASE_MAX_TIME_US  = 50000,
   parameter int SECTOR_ERASE_MAX_TIME_US = 2000000,
   parameter int CHIP_ERASE_MAX_TIME_US   = 20000000
) (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire logic                spi_sck,
   input  wire logic                spi_cs_n,
   input  wire logic                spi_mosi,
   input  wire logic                wp_n,
   input  wire logic                page_264_mode,
   input  wire logic                sw_protect_en,
   input  wire logic [PROT_W-1:0]   sector_protect,
   input  wire logic [PROT_W-1:0]   sector_lockdown,
   input  wire logic                arr_done,
   input  wire logic                arr_blank,
   output logic                     busy_ff,
   output logic                     erase_program_error_flag_ff,
   output logic                     arr_req_ff,
   output logic [PAGE_W-1:0]        arr_page_ff
);

   // Cycle budgets derived from the maximum erase times
   localparam logic [31:0] BLOCK_ERASE_MAX_CYC =
      32'(BLOCK_ERASE_MAX_TIME_US * (NS_PER_US / CLK_PERIOD_NS));
   localparam logic [31:0] SECTOR_ERASE_MAX_CYC =
      32'(SECTOR_ERASE_MAX_TIME_US * (NS_PER_US / CLK_PERIOD_NS));
   localparam logic [31:0] CHIP_ERASE_MAX_CYC =
      32'(CHIP_ERASE_MAX_TIME_US * (NS_PER_US / CLK_PERIOD_NS));

   spi_pins_t          pins_raw;
   spi_pins_t          pins_s;
   spi_pins_t          pins_d_ff;
   logic               wp_n_s;
   logic [3:0]         sync_q;
   logic               sck_rise;
   logic               cs_rise;
   logic               cs_fall;
   logic               cs_active;

   logic [2:0]         bit_ff;
   logic [2:0]         byte_cnt_ff;
   logic [7:0]         shift_ff;
   logic [7:0]         bytes_ff [CMD_BYTES];

   logic [23:0]        addr;
   logic [PAGE_W-1:0]  page;
   logic [3:0]         sec_num;
   erase_cmd_t         cmd;
   logic               chip_seq_ok;

   seq_state_t         state_ff;
   seq_state_t         nxt_state;
   logic [PAGE_W-1:0]  last_ff;
   logic [31:0]        tmo_cnt_ff;
   logic [31:0]        tmo_lim_ff;
   logic               wp_eff_ff;
   logic [PROT_W-1:0]  prot_ff;
   logic [PROT_W-1:0]  lock_ff;
   logic [4:0]         page_prot_idx;
   logic               page_skip;
   logic               start;
   logic               timeout;

   // Pins cross from the host domain through two flops
   assign pins_raw = '{sck: spi_sck, cs_n: spi_cs_n, mosi: spi_mosi};

   sync_2ff #(
      .W (4)
   ) u_sync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .d       ({pins_raw.sck, ~pins_raw.cs_n, pins_raw.mosi, ~wp_n}),
      .q       (sync_q)
   );

   // Active-low pins travel inverted so the flops clear to the idle level
   // and no false chip select edge or write protect follows reset
   assign pins_s = '{sck: sync_q[3], cs_n: ~sync_q[2], mosi: sync_q[1]};
   assign wp_n_s = ~sync_q[0];

   // Delayed copy of the synchronised pins for edge finding
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pins_d_ff <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      end else begin
         pins_d_ff <= pins_s;
      end
   end

   // Mode 0 and 3 both sample data on the rising serial clock edge
   assign sck_rise  = pins_s.sck & ~pins_d_ff.sck;
   assign cs_rise   = pins_s.cs_n & ~pins_d_ff.cs_n;
   assign cs_fall   = ~pins_s.cs_n & pins_d_ff.cs_n;
   assign cs_active = ~pins_s.cs_n & ~cs_fall;

   // Bit and byte counting within a frame
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bit_ff      <= 3'h0;
         byte_cnt_ff <= 3'h0;
         shift_ff    <= 8'h00;
      end else if (cs_fall) begin
         bit_ff      <= 3'h0;
         byte_cnt_ff <= 3'h0;
         shift_ff    <= 8'h00;
      end else if (cs_active && sck_rise) begin
         bit_ff   <= bit_ff + 3'h1;
         shift_ff <= {shift_ff[6:0], pins_s.mosi};
         // Count saturates so trailing bytes never disturb the capture
         if (bit_ff == BIT_LAST && byte_cnt_ff != BYTE_CNT_W + 3'h1) begin
            byte_cnt_ff <= byte_cnt_ff + 3'h1;
         end
      end
   end

   // Only the first four bytes are kept; anything later is dropped
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < CMD_BYTES; i++) begin
            bytes_ff[i] <= 8'h00;
         end
      end else if (cs_active && sck_rise && bit_ff == BIT_LAST &&
                   byte_cnt_ff < BYTE_CNT_W) begin
         bytes_ff[byte_cnt_ff[1:0]] <= {shift_ff[6:0], pins_s.mosi};
      end
   end

   // Page address from the three address bytes, layout set by page size
   assign addr = {bytes_ff[1], bytes_ff[2], bytes_ff[3]};
   assign page = page_264_mode ? addr[PAGE_LSB_264 +: PAGE_W]
                               : addr[PAGE_LSB_256 +: PAGE_W];
   assign sec_num = page[SEC_LSB +: 4];

   assign chip_seq_ok = bytes_ff[0] == OP_CHIP_ERASE_0 &&
                        bytes_ff[1] == OP_CHIP_ERASE_1 &&
                        bytes_ff[2] == OP_CHIP_ERASE_2 &&
                        bytes_ff[3] == OP_CHIP_ERASE_3;

   // Decode the captured frame into a page range
   always_comb begin
      cmd = '{kind: KIND_NONE, first: PAGE_ZERO, last: PAGE_ZERO};
      if (byte_cnt_ff >= BYTE_CNT_W) begin
         if (bytes_ff[0] == OP_BLOCK_ERASE) begin
            // Low three page bits are don't care, giving blocks 0..511
            cmd.kind  = KIND_BLOCK;
            cmd.first = {page[PAGE_W-1:BLK_LSB], 3'h0};
            cmd.last  = cmd.first | BLK_SPAN;
         end else if (bytes_ff[0] == OP_SECTOR_ERASE) begin
            cmd.kind = KIND_SECTOR;
            if (sec_num != SEC_NONE) begin
               cmd.first = {sec_num, 8'h00};
               cmd.last  = cmd.first | SEC_SPAN;
            end else if (page[SUB_BIT]) begin
               cmd.first = SUB_0B_FIRST;
               cmd.last  = SEC_SPAN;
            end else begin
               cmd.first = PAGE_ZERO;
               cmd.last  = BLK_SPAN;
            end
         end else if (chip_seq_ok) begin
            cmd.kind  = KIND_CHIP;
            cmd.first = PAGE_ZERO;
            cmd.last  = PAGE_LAST;
         end
      end
   end

   // Frame must end on a byte boundary; a busy device drops new commands
   assign start = cs_rise && bit_ff == ADDR_LSB_B && cmd.kind != KIND_NONE &&
                  state_ff == ST_IDLE;

   // Protection index of the page under erase
   always_comb begin
      if (arr_page_ff[SEC_LSB +: 4] != SEC_NONE) begin
         page_prot_idx = {1'b0, arr_page_ff[SEC_LSB +: 4]};
      end else if (arr_page_ff[SUB_BIT]) begin
         page_prot_idx = PROT_IDX_0B;
      end else begin
         page_prot_idx = 5'h00;
      end
   end

   // Protected sectors count only while protection is in force
   assign page_skip = lock_ff[page_prot_idx] |
                      (prot_ff[page_prot_idx] & (sw_protect_en | wp_eff_ff));

   assign timeout = tmo_cnt_ff >= tmo_lim_ff;

   // Write protect is frozen while an erase runs
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wp_eff_ff <= 1'b0;
      end else if (state_ff == ST_IDLE) begin
         wp_eff_ff <= ~wp_n_s;
      end
   end

   // Protection maps captured at start hold steady through the erase
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prot_ff <= '0;
         lock_ff <= '0;
      end else if (start) begin
         prot_ff <= sector_protect;
         lock_ff <= sector_lockdown;
      end
   end

   // Sequencer state
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (timeout) begin
               nxt_state = ST_DONE;
            end else if (!page_skip) begin
               nxt_state = ST_WAIT;
            end else if (arr_page_ff == last_ff) begin
               nxt_state = ST_DONE;
            end
         end
         ST_WAIT: begin
            if (timeout) begin
               nxt_state = ST_DONE;
            end else if (arr_done) begin
               nxt_state = (arr_page_ff == last_ff) ? ST_DONE : ST_SCAN;
            end
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Page pointer and range bookkeeping
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         arr_page_ff <= PAGE_ZERO;
         last_ff     <= PAGE_ZERO;
      end else if (start) begin
         arr_page_ff <= cmd.first;
         last_ff     <= cmd.last;
      end else if (state_ff == ST_SCAN && page_skip && arr_page_ff != last_ff) begin
         arr_page_ff <= arr_page_ff + 12'h001;
      end else if (state_ff == ST_WAIT && arr_done && arr_page_ff != last_ff) begin
         arr_page_ff <= arr_page_ff + 12'h001;
      end
   end

   // Request to the array holds until it reports the page done
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         arr_req_ff <= 1'b0;
      end else if (nxt_state == ST_WAIT && !(state_ff == ST_WAIT && arr_done)) begin
         arr_req_ff <= 1'b1;
      end else begin
         arr_req_ff <= 1'b0;
      end
   end

   // Watchdog against the maximum erase time of each kind
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tmo_cnt_ff <= 32'h0;
         tmo_lim_ff <= 32'h0;
      end else if (start) begin
         tmo_cnt_ff <= 32'h0;
         case (cmd.kind)
            KIND_BLOCK:  tmo_lim_ff <= BLOCK_ERASE_MAX_CYC;
            KIND_SECTOR: tmo_lim_ff <= SECTOR_ERASE_MAX_CYC;
            default:     tmo_lim_ff <= CHIP_ERASE_MAX_CYC;
         endcase
      end else if (state_ff == ST_SCAN || state_ff == ST_WAIT) begin
         tmo_cnt_ff <= tmo_cnt_ff + 32'h1;
      end
   end

   // Busy spans from the chip select rise until the last page settles
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         busy_ff <= 1'b0;
      end else if (start) begin
         busy_ff <= 1'b1;
      end else if (state_ff == ST_DONE) begin
         busy_ff <= 1'b0;
      end
   end

   // Error flag is cleared when a new erase starts and set by any failure
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         erase_program_error_flag_ff <= 1'b0;
      end else if (state_ff == ST_WAIT && arr_done && !arr_blank) begin
         erase_program_error_flag_ff <= 1'b1;
      end else if ((state_ff == ST_SCAN || state_ff == ST_WAIT) && timeout) begin
         erase_program_error_flag_ff <= 1'b1;
      end else if (start) begin
         erase_program_error_flag_ff <= 1'b0;
      end
   end

endmodule

// [tb/erase_seq_chk.sv]
// Concurrent checks on the erase sequencer ports
`timescale 1ns/1ps
module erase_seq_chk
   import erase_seq_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              nrst,
   input wire logic              spi_cs_n,
   input wire logic              arr_done,
   input wire logic              arr_blank,
   input wire logic              busy_ff,
   input wire logic              erase_program_error_flag_ff,
   input wire logic              arr_req_ff,
   input wire logic [PAGE_W-1:0] arr_page_ff
);
   logic [PAGE_W-1:0] last_pg_ff;
   logic              seen_ff;

   // Last finished page, so a later request can be ordered against it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         last_pg_ff <= 12'h000;
         seen_ff <= 1'b0;
      end else if (arr_req_ff && arr_done) begin
         last_pg_ff <= arr_page_ff;
         seen_ff <= 1'b1;
      end else if (!busy_ff) begin
         seen_ff <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence page_done;
      arr_req_ff && arr_done;
   endsequence
   sequence cs_low_run;
      !spi_cs_n [*4];
   endsequence

   chk_req_in_busy: assert property (arr_req_ff |-> busy_ff)
      else $error("array request outside busy");
   chk_req_holds: assert property (arr_req_ff && !arr_done |=> arr_req_ff && $stable(arr_page_ff))
      else $error("array request dropped or moved early");
   chk_req_drops: assert property (page_done |=> !arr_req_ff)
      else $error("array request not dropped after done");
   chk_page_order: assert property ($rose(arr_req_ff) && seen_ff |-> arr_page_ff > last_pg_ff)
      else $error("pages not ascending");
   chk_start_on_cs: assert property ($rose(busy_ff) |-> spi_cs_n && $past(spi_cs_n, 2))
      else $error("erase started without chip select rise");
   chk_no_start_mid: assert property (cs_low_run |-> !$rose(busy_ff))
      else $error("erase started inside a frame");
   chk_err_clear: assert property ($fell(erase_program_error_flag_ff) |-> busy_ff)
      else $error("error flag cleared without new erase");
   chk_err_cause: assert property ($rose(erase_program_error_flag_ff) |-> $past(busy_ff))
      else $error("error flag set while idle");
   chk_blank_err: assert property ((page_done and !arr_blank) |=> erase_program_error_flag_ff)
      else $error("failed page did not set error flag");
   chk_busy_tail: assert property ($fell(busy_ff) |-> !arr_req_ff && !$past(arr_req_ff))
      else $error("busy dropped with request pending");
endmodule

bind erase_seq erase_seq_chk u_erase_seq_chk (
   .clk_sys                     (clk_sys),
   .nrst                        (nrst),
   .spi_cs_n                    (spi_cs_n),
   .arr_done                    (arr_done),
   .arr_blank                   (arr_blank),
   .busy_ff                     (busy_ff),
   .erase_program_error_flag_ff (erase_program_error_flag_ff),
   .arr_req_ff                  (arr_req_ff),
   .arr_page_ff                 (arr_page_ff)
);

// [tb/spi_host_model.sv]
// Behavioural serial host that clocks whole frames into the device pins
`timescale 1ns/1ps
module spi_host_model
   import erase_seq_pkg::*;
(
   input wire logic clk_sys,
   output spi_pins_t pins
);
   // Mode 0: clock rests low and stands still between frames
   initial pins = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};

   // Half of a 400 ns serial clock period
   task automatic half;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask

   // Bits go MSB first; a frame may stop short of a byte boundary on purpose
   task automatic send(input logic [47:0] fr, input int nbits);
      int i;
      @(posedge clk_sys);
      #1;
      pins.cs_n = 1'b0;
      for (i = nbits - 1; i >= 0; i--) begin
         pins.mosi = fr[i];
         half();
         pins.sck = 1'b1;
         half();
         pins.sck = 1'b0;
      end
      half();
      pins.cs_n = 1'b1;
      pins.mosi = ~pins.mosi; // Released line shows no stale data
   endtask
endmodule

// [tb/tb_erase_seq.sv]
// Self-checking bench for the erase sequencer
`timescale 1ns/1ps
module tb_erase_seq;
   import erase_seq_pkg::*;
   logic              clk_sys = 1'b0;
   logic              nrst = 1'b0;
   spi_pins_t         pins;
   logic              wp_n = 1'b1;
   logic              page_264_mode = 1'b1;
   logic              sw_protect_en = 1'b0;
   logic [PROT_W-1:0] sector_protect = 17'h00000;
   logic [PROT_W-1:0] sector_lockdown = 17'h00000;
   logic              arr_done = 1'b0;
   logic              arr_blank = 1'b1;
   logic              busy_ff;
   logic              err_flag;
   logic              arr_req_ff;
   logic [11:0]       arr_page_ff;
   logic [11:0]       first_pg, last_pg;
   logic [11:0]       fail_pg = 12'h000;
   logic              fail_en = 1'b0;
   logic              order_bad;
   int                n_pg, cnt, lat;
   int                n_errors = 0;
   int                n_tests = 0;

   always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

   erase_seq #(
      .BLOCK_ERASE_MAX_TIME_US  (5),
      .SECTOR_ERASE_MAX_TIME_US (100),
      .CHIP_ERASE_MAX_TIME_US   (1000)
   ) u_erase_seq (
      .clk_sys                     (clk_sys),
      .nrst                        (nrst),
      .spi_sck                     (pins.sck),
      .spi_cs_n                    (pins.cs_n),
      .spi_mosi                    (pins.mosi),
      .wp_n                        (wp_n),
      .page_264_mode               (page_264_mode),
      .sw_protect_en               (sw_protect_en),
      .sector_protect              (sector_protect),
      .sector_lockdown             (sector_lockdown),
      .arr_done                    (arr_done),
      .arr_blank                   (arr_blank),
      .busy_ff                     (busy_ff),
      .erase_program_error_flag_ff (err_flag),
      .arr_req_ff                  (arr_req_ff),
      .arr_page_ff                 (arr_page_ff)
   );

   spi_host_model u_spi_host_model (
      .clk_sys (clk_sys),
      .pins    (pins)
   );

   // Array answers each page after lat cycles; one chosen page may fail blank check
   always @(posedge clk_sys) begin
      #1;
      if (arr_done) begin
         arr_done = 1'b0;
         cnt = 0;
      end else if (arr_req_ff === 1'b1) begin
         cnt++;
         if (cnt >= lat) begin
            arr_done = 1'b1;
            arr_blank = !(fail_en && arr_page_ff === fail_pg);
            if (n_pg > 0 && arr_page_ff <= last_pg) order_bad = 1'b1;
            if (n_pg == 0) first_pg = arr_page_ff;
            last_pg = arr_page_ff;
            n_pg++;
         end
      end
   end

   task automatic stop_test;
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [47:0] cmd(input logic [7:0] op, input logic [23:0] a);
      cmd = {16'h0000, op, a};
   endfunction

   // Frame out, then a bounded wait for busy to show up
   task automatic start(input logic [47:0] fr, input int nb, input logic acc);
      int k;
      n_pg = 0;
      order_bad = 1'b0;
      u_spi_host_model.send(fr, nb);
      for (k = 0; k < 10 && busy_ff !== 1'b1; k++) begin
         @(posedge clk_sys);
         #1;
      end
      check_bit(busy_ff, acc);
   endtask

   // Host waits up to 30000 cycles for busy to clear, then checks page count, range, order and error flag
   task automatic finish(input int en, input logic [11:0] ef, input logic [11:0] el,
                         input logic ee);
      int k;
      for (k = 0; k < 30000 && busy_ff !== 1'b0; k++) begin
         @(posedge clk_sys);
         #1;
      end
      if (k == 30000) begin
         n_errors++;
         stop_test();
      end
      check_val(n_pg[15:0], en[15:0]);
      if (en > 0) begin
         check_val({4'h0, first_pg}, {4'h0, ef});
         check_val({4'h0, last_pg}, {4'h0, el});
      end
      check_bit(order_bad, 1'b0);
      check_bit(err_flag, ee);
   endtask

   task automatic run(input logic [47:0] fr, input int nb, input logic acc, input int en,
                      input logic [11:0] ef, input logic [11:0] el, input logic ee);
      start(fr, nb, acc);
      finish(en, ef, el, ee);
   endtask

   // Main sequence
   initial begin
      lat = 3;
      repeat (20) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      run(cmd(OP_BLOCK_ERASE, 24'h1ffa00), 32, 1, 8, 12'hff8, 12'hfff, 0);
      lat = 1;
      run(cmd(OP_SECTOR_ERASE, 24'h001600), 32, 1, 248, 12'h008, 12'h0ff, 0);
      run(cmd(OP_SECTOR_ERASE, 24'h034600), 32, 1, 256, 12'h100, 12'h1ff, 0);
      page_264_mode = 1'b0;
      fail_pg = 12'h00c;
      fail_en = 1'b1;
      lat = 3;
      run(cmd(OP_BLOCK_ERASE, 24'h000fff), 32, 1, 8, 12'h008, 12'h00f, 1);
      fail_en = 1'b0;
      lat = 1;
      run(cmd(OP_SECTOR_ERASE, 24'h000700), 32, 1, 8, 12'h000, 12'h007, 0);
      run(cmd(OP_SECTOR_ERASE, 24'h0fbeef), 32, 1, 256, 12'hf00, 12'hfff, 0);
      run(cmd(OP_BLOCK_ERASE, 24'h000fff) >> 1, 31, 0, 0, 12'h000, 12'h000, 0);
      run(cmd(8'h51, 24'h000000), 32, 0, 0, 12'h000, 12'h000, 0);
      run(48'h0000c794809b, 32, 0, 0, 12'h000, 12'h000, 0);
      run(48'h000000c79480, 24, 0, 0, 12'h000, 12'h000, 0);
      sw_protect_en = 1'b1;
      sector_protect = 17'h00004;
      run(cmd(OP_BLOCK_ERASE, 24'h020000), 32, 1, 0, 12'h000, 12'h000, 0);
      sw_protect_en = 1'b0;
      sector_lockdown = 17'h08000;
      start(48'hc794809a00ff, 48, 1);
      u_spi_host_model.send(cmd(OP_BLOCK_ERASE, 24'h000000), 32);
      wp_n = 1'b0;
      finish(3840, 12'h000, 12'heff, 0);
      wp_n = 1'b1;
      stop_test();
   end
endmodule
